// ### hdl/aabp_pkg.sv
// Package with register map, field codes and timing constants for the analog/alarm/brake parameter block
// How it works
// - Reading (live sample minus zero reference and offset) compared against trip level gives the sensor state for feed moves.
// - Trip level is signed millivolts, clamped to -10000..10000 (or 0..5000 unipolar).
// - Global offset is signed millivolts, clamped to -10000..10000 (or -5000..5000).
// - Offset register view is in data units, offset word times a scale factor.
// - Channel offset command carries selector 1 to 3; other selectors are refused.
// - Selector 1 and 2 pick single-ended channels, 3 picks the differential input.
// - Channel offset stored as 0..255 code, taken as whole volts, clamped to 10.
// - Queued alarm clear clears alarms like instant clear, at its own write; nothing is queued.
// - Queued alarm clear restarts the status LED blink timer.
// - Neither alarm clear re-enables the motor; enable command is separate.
// - Auto-zero captures the present analog sample as the zero reference.
// - Reported reading equals live sample minus captured zero reference minus global offset.
// - Release delay honoured only while brake function code is 1 or 2.
// - Release countdown starts as soon as drive is enabled and brake output set.
// - Feed and jog moves held until release countdown expires.
// - Both delays are milliseconds, 0 to 32767.
// - Disable with brake active sets brake at once, current off after apply delay.
// - Code 1 output closed while enabled, code 2 inverted, code 3 output freed.
// - Instant alarm clear leaves an alarm whose cause still persists.
package aabp_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] AABP_TRIP_LEVEL = 8'h00;
	localparam logic [7:0] AABP_OFFSET = 8'h04;
	localparam logic [7:0] AABP_OFFSET_DATA = 8'h08;
	localparam logic [7:0] AABP_CHAN_OFFSET = 8'h0c;
	localparam logic [7:0] AABP_BRK_REL = 8'h10;
	localparam logic [7:0] AABP_BRK_APP = 8'h14;
	localparam logic [7:0] AABP_BRK_FUNC = 8'h18;
	localparam logic [7:0] AABP_CMD = 8'h1c;
	localparam logic [7:0] AABP_STATUS = 8'h20;
	localparam logic [7:0] AABP_READING = 8'h24;
	localparam logic [7:0] AABP_ZERO_REF = 8'h28;
	// ----------------------------------------
	// Command bits in AABP_CMD
	// ----------------------------------------
	localparam int AABP_CMD_QCLR = 0;
	localparam int AABP_CMD_ICLR = 1;
	localparam int AABP_CMD_ZERO = 2;
	localparam int AABP_CMD_ENA = 3;
	localparam int AABP_CMD_DIS = 4;
	// ----------------------------------------
	// Ranges, codes and reset values
	// ----------------------------------------
	localparam logic signed [15:0] AABP_BIP_MAX = 16'sh2710;
	localparam logic signed [15:0] AABP_BIP_MIN = -16'sh2710;
	localparam logic signed [15:0] AABP_UNI_MAX = 16'sh1388;
	localparam logic signed [15:0] AABP_UNI_MIN = -16'sh1388;
	localparam logic signed [15:0] AABP_ZERO_MV = 16'sh0000;
	localparam logic [7:0] AABP_CHAN_MAX_V = 8'h0a;
	localparam logic [14:0] AABP_DELAY_MAX = 15'h7fff;
	localparam logic [1:0] AABP_SEL_MIN = 2'h1;
	localparam logic [1:0] AABP_BRK_CODE_FREE = 2'h3;
	localparam logic [1:0] AABP_BRK_CODE_ON = 2'h1;
	localparam logic [1:0] AABP_BRK_CODE_INV = 2'h2;
	localparam logic [1:0] AABP_BRK_RESET = 2'h3;
	localparam logic [15:0] AABP_DATA_SCALE = 16'h0001;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int AABP_CLK_MHZ = 125;
	localparam int AABP_TICK_US = 1000;
	localparam int AABP_TICK_CYC = AABP_CLK_MHZ * AABP_TICK_US;
	localparam logic [16:0] AABP_TICK_LAST = 17'(AABP_TICK_CYC - 1);
	localparam logic [15:0] AABP_BLINK_RESET = 16'h0000;
	// ----------------------------------------
	// Brake sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		AABP_OFF = 2'b00,
		AABP_RELEASE = 2'b01,
		AABP_RUN = 2'b10,
		AABP_APPLY = 2'b11
	} aabp_brk_e;
endpackage

// ### hdl/aabp_top.sv
// Analog trip/offset/zero, alarm clear and brake sequencing with an APB register file
`timescale 1ns/10ps
module aabp_top import aabp_pkg::*; #(
	parameter logic [16:0] TICK_LAST = AABP_TICK_LAST, // Cycles per 1 ms tick, minus one
	parameter bit UNIPOLAR = 1'b0 // Smaller limits with unipolar input ranges
) (
	input wire logic pclk, // APB clock, 125 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic signed [15:0] ain_mv, // Analog sample, signed millivolts
	input wire logic fault_in, // Fault condition pin, active high
	output logic sensor_hit, // Feed-to-sensor trigger state
	output logic alarm, // Latched alarm
	output logic led_blink, // Status LED blink phase
	output logic brake_out, // Brake output pin level
	output logic motor_current, // Motor current enabled
	output logic move_hold // Feed and jog moves held off
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic signed [15:0] clamp_mv(input logic signed [15:0] v, input logic signed [15:0] lo,
		input logic signed [15:0] hi);
		clamp_mv = (v > hi) ? hi : ((v < lo) ? lo : v);
	endfunction

	logic [1:0] fault_sync_ff;
	logic signed [15:0] ain_s1_ff, ain_ff;
	logic signed [15:0] trip_ff, nxt_trip, offs_ff, nxt_offs, zref_ff, nxt_zref, reading_ff, nxt_reading;
	logic [7:0] chan_ff [1:3];
	logic [7:0] nxt_chan [1:3];
	logic [14:0] rel_ff, nxt_rel, app_ff, nxt_app, cnt_ff, nxt_cnt;
	logic [1:0] func_ff, nxt_func;
	logic alarm_ff, nxt_alarm, sensor_ff, nxt_sensor, cmd_err_ff, nxt_cmd_err;
	logic [16:0] tick_cnt_ff, nxt_tick_cnt;
	logic [15:0] blink_ff, nxt_blink;
	aabp_brk_e st_ff, nxt_st;
	logic brk_ff, nxt_brk, cur_ff, nxt_cur, hold_ff, nxt_hold;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic wr, rd, tick, qclr, iclr, zero_cmd, ena_cmd, dis_cmd, func_active, mapped;
	logic signed [15:0] lo_lim, trip_lo;
	logic [1:0] sel;

	// Pins pass two flops before use; the sample bus is assumed held steady across two clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_sync_ff <= 2'h0;
			ain_s1_ff <= AABP_ZERO_MV;
			ain_ff <= AABP_ZERO_MV;
		end else begin
			fault_sync_ff <= {fault_sync_ff[0], fault_in};
			ain_s1_ff <= ain_mv;
			ain_ff <= ain_s1_ff;
		end
	end

	// ----------------------------------------
	// APB decode and parameters
	// ----------------------------------------
	always_comb begin
		wr = psel && penable && pwrite && pready_ff;
		rd = psel && !penable && !pwrite;
		sel = pwdata[17:16];
		lo_lim = UNIPOLAR ? AABP_UNI_MIN : AABP_BIP_MIN;
		trip_lo = UNIPOLAR ? AABP_ZERO_MV : AABP_BIP_MIN;
		qclr = wr && paddr == AABP_CMD && pwdata[AABP_CMD_QCLR];
		iclr = wr && paddr == AABP_CMD && pwdata[AABP_CMD_ICLR];
		zero_cmd = wr && paddr == AABP_CMD && pwdata[AABP_CMD_ZERO];
		ena_cmd = wr && paddr == AABP_CMD && pwdata[AABP_CMD_ENA];
		dis_cmd = wr && paddr == AABP_CMD && pwdata[AABP_CMD_DIS];
		mapped = paddr inside {AABP_TRIP_LEVEL, AABP_OFFSET, AABP_OFFSET_DATA, AABP_CHAN_OFFSET, AABP_BRK_REL,
			AABP_BRK_APP, AABP_BRK_FUNC, AABP_CMD, AABP_STATUS, AABP_READING, AABP_ZERO_REF};
		nxt_trip = trip_ff;
		nxt_offs = offs_ff;
		nxt_rel = rel_ff;
		nxt_app = app_ff;
		nxt_func = func_ff;
		nxt_zref = zref_ff;
		nxt_cmd_err = cmd_err_ff;
		for (int i = 1; i <= 3; i++) begin
			nxt_chan[i] = chan_ff[i];
		end
		if (wr) begin
			case (paddr)
				AABP_TRIP_LEVEL: nxt_trip = clamp_mv(pwdata[15:0], trip_lo,
					UNIPOLAR ? AABP_UNI_MAX : AABP_BIP_MAX);
				AABP_OFFSET: nxt_offs = clamp_mv(pwdata[15:0], lo_lim, UNIPOLAR ? AABP_UNI_MAX : AABP_BIP_MAX);
				AABP_OFFSET_DATA: nxt_offs = clamp_mv(16'(pwdata[15:0] / AABP_DATA_SCALE), lo_lim,
					UNIPOLAR ? AABP_UNI_MAX : AABP_BIP_MAX);
				AABP_CHAN_OFFSET: begin
					if (sel >= AABP_SEL_MIN) begin
						// 1, 2 single-ended, 3 differential; code taken as whole volts
						nxt_chan[sel] = (pwdata[7:0] > AABP_CHAN_MAX_V) ? AABP_CHAN_MAX_V : pwdata[7:0];
						nxt_cmd_err = 1'b0;
					end else begin
						nxt_cmd_err = 1'b1;
					end
				end
				AABP_BRK_REL: nxt_rel = pwdata[14:0];
				AABP_BRK_APP: nxt_app = pwdata[14:0];
				AABP_BRK_FUNC: nxt_func = (pwdata[1:0] == 2'h0) ? func_ff : pwdata[1:0];
				default: nxt_cmd_err = cmd_err_ff;
			endcase
		end
		if (zero_cmd) begin
			nxt_zref = ain_ff;
		end
	end

	// ----------------------------------------
	// Analog path, alarm and LED
	// ----------------------------------------
	always_comb begin
		nxt_reading = 16'(ain_ff - zref_ff - offs_ff);
		nxt_sensor = nxt_reading >= trip_ff;
		// Either clear drops the alarm at its own write, nothing is queued; a fault still present wins over any clear
		nxt_alarm = fault_sync_ff[1] || (alarm_ff && !(qclr || iclr));
		nxt_tick_cnt = (tick_cnt_ff == TICK_LAST) ? 17'h0 : 17'(tick_cnt_ff + 17'h1);
		tick = tick_cnt_ff == TICK_LAST;
		nxt_blink = qclr ? AABP_BLINK_RESET : (tick ? 16'(blink_ff + 16'h1) : blink_ff);
	end

	// ----------------------------------------
	// Brake sequencer
	// ----------------------------------------
	always_comb begin
		func_active = func_ff == AABP_BRK_CODE_ON || func_ff == AABP_BRK_CODE_INV;
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_brk = brk_ff;
		nxt_cur = cur_ff;
		nxt_hold = hold_ff;
		case (st_ff)
			AABP_OFF: begin
				nxt_cur = 1'b0;
				nxt_hold = 1'b1;
				// Disabled level follows the code, so a code written while off shows at once
				nxt_brk = (func_ff == AABP_BRK_CODE_INV);
				// Only the enable command powers the motor; alarm clears never do
				if (ena_cmd) begin
					nxt_cur = 1'b1;
					nxt_brk = (func_ff == AABP_BRK_CODE_ON);
					nxt_cnt = rel_ff;
					if (func_active && rel_ff != 15'h0) begin
						nxt_st = AABP_RELEASE;
					end else begin
						nxt_st = AABP_RUN;
						nxt_hold = 1'b0;
					end
				end
			end
			AABP_RELEASE: begin
				nxt_brk = (func_ff == AABP_BRK_CODE_ON);
				if (dis_cmd) begin
					nxt_st = AABP_APPLY;
					nxt_brk = (func_ff == AABP_BRK_CODE_INV);
					nxt_cnt = app_ff;
				end else if (tick) begin
					nxt_cnt = 15'(cnt_ff - 15'h1);
					if (cnt_ff == 15'h1) begin
						nxt_st = AABP_RUN;
						nxt_hold = 1'b0;
					end
				end
			end
			AABP_RUN: begin
				nxt_brk = (func_ff == AABP_BRK_CODE_ON);
				if (dis_cmd) begin
					nxt_hold = 1'b1;
					nxt_brk = (func_ff == AABP_BRK_CODE_INV);
					nxt_cnt = app_ff;
					if (func_active && app_ff != 15'h0) begin
						nxt_st = AABP_APPLY;
					end else begin
						nxt_st = AABP_OFF;
						nxt_cur = 1'b0;
					end
				end
			end
			AABP_APPLY: begin
				nxt_hold = 1'b1;
				nxt_brk = (func_ff == AABP_BRK_CODE_INV);
				if (tick) begin
					nxt_cnt = 15'(cnt_ff - 15'h1);
					if (cnt_ff <= 15'h1) begin
						nxt_st = AABP_OFF;
						nxt_cur = 1'b0;
					end
				end
			end
			default: nxt_st = AABP_OFF;
		endcase
		// Code 3 frees the pin; it is then held low here
		if (func_ff == AABP_BRK_CODE_FREE) begin
			nxt_brk = 1'b0;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		nxt_pready = psel && !penable;
		nxt_pslverr = psel && !penable && !mapped;
		nxt_prdata = 32'h0;
		if (rd) begin
			case (paddr)
				AABP_TRIP_LEVEL: nxt_prdata = 32'(trip_ff);
				AABP_OFFSET: nxt_prdata = 32'(offs_ff);
				AABP_OFFSET_DATA: nxt_prdata = 32'(offs_ff) * 32'(AABP_DATA_SCALE);
				AABP_CHAN_OFFSET: nxt_prdata = {8'h0, chan_ff[3], chan_ff[2], chan_ff[1]};
				AABP_BRK_REL: nxt_prdata = {17'h0, rel_ff};
				AABP_BRK_APP: nxt_prdata = {17'h0, app_ff};
				AABP_BRK_FUNC: nxt_prdata = {30'h0, func_ff};
				AABP_STATUS: nxt_prdata = {24'h0, cmd_err_ff, st_ff, hold_ff, cur_ff, brk_ff, sensor_ff, alarm_ff};
				AABP_READING: nxt_prdata = 32'(reading_ff);
				AABP_ZERO_REF: nxt_prdata = 32'(zref_ff);
				default: nxt_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_ff <= AABP_ZERO_MV;
			offs_ff <= AABP_ZERO_MV;
			zref_ff <= AABP_ZERO_MV;
			reading_ff <= AABP_ZERO_MV;
			for (int i = 1; i <= 3; i++) begin
				chan_ff[i] <= 8'h0;
			end
			rel_ff <= 15'h0;
			app_ff <= 15'h0;
			func_ff <= AABP_BRK_RESET;
			cmd_err_ff <= 1'b0;
			alarm_ff <= 1'b0;
			sensor_ff <= 1'b0;
			tick_cnt_ff <= 17'h0;
			blink_ff <= AABP_BLINK_RESET;
			st_ff <= AABP_OFF;
			cnt_ff <= 15'h0;
			brk_ff <= 1'b0;
			cur_ff <= 1'b0;
			hold_ff <= 1'b1;
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			trip_ff <= nxt_trip;
			offs_ff <= nxt_offs;
			zref_ff <= nxt_zref;
			reading_ff <= nxt_reading;
			chan_ff <= nxt_chan;
			rel_ff <= nxt_rel;
			app_ff <= nxt_app;
			func_ff <= nxt_func;
			cmd_err_ff <= nxt_cmd_err;
			alarm_ff <= nxt_alarm;
			sensor_ff <= nxt_sensor;
			tick_cnt_ff <= nxt_tick_cnt;
			blink_ff <= nxt_blink;
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			brk_ff <= nxt_brk;
			cur_ff <= nxt_cur;
			hold_ff <= nxt_hold;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign sensor_hit = sensor_ff;
	assign alarm = alarm_ff;
	assign led_blink = blink_ff[8];
	assign brake_out = brk_ff;
	assign motor_current = cur_ff;
	assign move_hold = hold_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_fault_keeps_alarm;
		@(posedge pclk) disable iff (!presetn) fault_sync_ff[1] |=> alarm_ff;
	endproperty
	a_fault_keeps_alarm: assert property (p_fault_keeps_alarm) else $error("alarm cleared with fault present");
	property p_clear_drops_alarm;
		@(posedge pclk) disable iff (!presetn) (qclr && !fault_sync_ff[1]) |=> !alarm_ff;
	endproperty
	a_clear_drops_alarm: assert property (p_clear_drops_alarm) else $error("queued clear left alarm");
	property p_blink_restart;
		@(posedge pclk) disable iff (!presetn) qclr |=> blink_ff == AABP_BLINK_RESET;
	endproperty
	a_blink_restart: assert property (p_blink_restart) else $error("blink timer not restarted");
	property p_no_reenable;
		@(posedge pclk) disable iff (!presetn) (st_ff == AABP_OFF && !ena_cmd) |=> !cur_ff;
	endproperty
	a_no_reenable: assert property (p_no_reenable) else $error("motor on without enable");
	property p_zero_capture;
		@(posedge pclk) disable iff (!presetn) zero_cmd |=> zref_ff == $past(ain_ff);
	endproperty
	a_zero_capture: assert property (p_zero_capture) else $error("zero reference not captured");
	property p_reading;
		@(posedge pclk) disable iff (!presetn) 1'b1 |=> reading_ff == 16'($past(ain_ff) - $past(zref_ff) - $past(offs_ff));
	endproperty
	a_reading: assert property (p_reading) else $error("reading not live minus zero");
	property p_hold_in_release;
		@(posedge pclk) disable iff (!presetn) st_ff == AABP_RELEASE |-> move_hold;
	endproperty
	a_hold_in_release: assert property (p_hold_in_release) else $error("move allowed during release");
	property p_release_only_active;
		@(posedge pclk) disable iff (!presetn) (st_ff == AABP_OFF && ena_cmd && !func_active) |=> st_ff == AABP_RUN;
	endproperty
	a_release_only_active: assert property (p_release_only_active) else $error("delay with brake inactive");
	property p_apply_current;
		@(posedge pclk) disable iff (!presetn)
			st_ff == AABP_APPLY |-> cur_ff && brk_ff == ($past(func_ff) == AABP_BRK_CODE_INV);
	endproperty
	a_apply_current: assert property (p_apply_current) else $error("current off before apply delay");
	property p_cancel_release;
		@(posedge pclk) disable iff (!presetn) (st_ff == AABP_RELEASE && dis_cmd) |=> st_ff == AABP_APPLY;
	endproperty
	a_cancel_release: assert property (p_cancel_release) else $error("disable ignored in release");
	c_release: cover property (@(posedge pclk) disable iff (!presetn) st_ff == AABP_RELEASE ##1 st_ff == AABP_RUN);
	c_apply: cover property (@(posedge pclk) disable iff (!presetn) st_ff == AABP_APPLY ##1 st_ff == AABP_OFF);
	c_zero: cover property (@(posedge pclk) disable iff (!presetn) zero_cmd);
	c_clear: cover property (@(posedge pclk) disable iff (!presetn) alarm_ff ##1 !alarm_ff);
endmodule

// ### verification/aabp_plant.sv
// Model of the analog front end and fault source that feed the block
`timescale 1ns/10ps
module aabp_plant (
	input wire logic pclk, // System clock
	input wire logic signed [15:0] set_mv, // Voltage the bench applies, millivolts
	input wire logic set_fault, // Fault cause the bench applies
	output logic signed [15:0] ain_mv, // Converted analog sample
	output logic fault_in // Fault condition seen by the block
);
	// ----------------------------------------
	// Conversion
	// ----------------------------------------
	// One cycle of conversion latency, like a real sampler; never faster than the pin
	always_ff @(posedge pclk) begin
		ain_mv <= set_mv;
		fault_in <= set_fault;
	end
endmodule

// ### verification/analog_alarm_brake_params_bench.sv
// Self-checking bench for the analog, alarm and brake parameter block
`timescale 1ns/10ps
module analog_alarm_brake_params_bench import aabp_pkg::*;;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, set_fault = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, sensor_hit, alarm, led_blink, brake_out, motor_current, move_hold, fault_in;
	logic signed [15:0] ain_mv, set_mv = 16'sh0000;
	int mismatches = 0, cmp_count = 0, n;
	always #4 pclk = ~pclk;
	aabp_top #(.TICK_LAST(17'h00009), .UNIPOLAR(1'b0)) aabp_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ain_mv(ain_mv), .fault_in(fault_in), .sensor_hit(sensor_hit),
		.alarm(alarm), .led_blink(led_blink), .brake_out(brake_out), .motor_current(motor_current),
		.move_hold(move_hold));
	aabp_plant aabp_plant_inst (.pclk(pclk), .set_mv(set_mv), .set_fault(set_fault), .ain_mv(ain_mv),
		.fault_in(fault_in));
	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task test_done();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// ----------------------------------------
	// Bus and pin helpers
	// ----------------------------------------
	// Request is held until pready is sampled high, then released at that same edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			chk("pready wait", 32'h0, 32'h1);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task cyc(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	task setin(input logic signed [15:0] mv, input logic f);
		@(posedge pclk);
		set_mv <= mv;
		set_fault <= f;
		cyc(6);
	endtask
	// Counts cycles until move_hold (which 0) or motor_current (which 1) reaches v
	task wait_for(input int which, input logic v, output int cnt);
		cnt = 0;
		while (((which == 0) ? move_hold : motor_current) !== v && cnt < 3000) begin
			cyc(1);
			cnt++;
		end
		if (cnt >= 3000) begin
			chk("output wait", 32'h0, 32'h1);
			test_done();
		end
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		cyc(1);
		chk("hold after reset", 32'(move_hold), 32'h1);
		rdchk("func reset", AABP_BRK_FUNC, 32'h3);
		wr(AABP_TRIP_LEVEL, 32'h00004e20);
		rdchk("trip high clamp", AABP_TRIP_LEVEL, 32'h00002710);
		wr(AABP_TRIP_LEVEL, 32'hffffb1e0);
		rdchk("trip low clamp", AABP_TRIP_LEVEL, 32'hffffd8f0);
		wr(AABP_TRIP_LEVEL, 32'h00000fa0);
		setin(16'sh0fa0, 1'b0);
		chk("sensor at level", 32'(sensor_hit), 32'h1);
		setin(16'sh0f9f, 1'b0);
		chk("sensor below", 32'(sensor_hit), 32'h0);
		wr(AABP_OFFSET, 32'h00003a98);
		rdchk("offset clamp", AABP_OFFSET, 32'h00002710);
		rdchk("offset data view", AABP_OFFSET_DATA, 32'h00002710);
		wr(AABP_OFFSET, 32'h000001f4);
		setin(16'sh1194, 1'b0);
		rdchk("offset in reading", AABP_READING, 32'h00000fa0);
		wr(AABP_OFFSET, 32'h0);
		wr(AABP_CHAN_OFFSET, 32'h00010003);
		wr(AABP_CHAN_OFFSET, 32'h00020007);
		wr(AABP_CHAN_OFFSET, 32'h000300c8);
		wr(AABP_CHAN_OFFSET, 32'h00000005);
		rdchk("channel offsets", AABP_CHAN_OFFSET, 32'h000a0703);
		apb(1'b0, AABP_STATUS, 32'h0);
		chk("selector refused", 32'(rd[7]), 32'h1);
		apb(1'b1, 8'h3c, 32'h1);
		chk("unmapped write err", 32'(err), 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped read err", {31'h0, err}, 32'h1);
		chk("unmapped read data", rd, 32'h0);
		setin(16'sh03e8, 1'b0);
		wr(AABP_CMD, 32'h4);
		setin(16'sh0fa0, 1'b0);
		rdchk("reading after zero", AABP_READING, 32'h00000bb8);
		rdchk("zero reference", AABP_ZERO_REF, 32'h000003e8);
		for (int b = 0; b < 2; b++) begin
			setin(16'sh0fa0, 1'b1);
			chk("alarm raised", 32'(alarm), 32'h1);
			setin(16'sh0fa0, 1'b0);
			cyc(20);
			wr(AABP_CMD, (b == 0) ? 32'h2 : 32'h1);
			cyc(2);
			chk("alarm cleared", 32'(alarm), 32'h0);
		end
		setin(16'sh0fa0, 1'b1);
		wr(AABP_CMD, 32'h2);
		cyc(2);
		chk("persisting alarm", 32'(alarm), 32'h1);
		setin(16'sh0fa0, 1'b0);
		n = 0;
		while (led_blink !== 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk("blink seen", 32'(led_blink), 32'h1);
		wr(AABP_CMD, 32'h1);
		cyc(2);
		chk("blink restarted", 32'(led_blink), 32'h0);
		chk("no re-enable", 32'(motor_current), 32'h0);
		wr(AABP_BRK_REL, 32'h00007fff);
		rdchk("release max", AABP_BRK_REL, 32'h00007fff);
		wr(AABP_BRK_REL, 32'h5);
		wr(AABP_BRK_APP, 32'h4);
		rdchk("apply delay", AABP_BRK_APP, 32'h4);
		wr(AABP_BRK_FUNC, 32'h0);
		rdchk("func zero ignored", AABP_BRK_FUNC, 32'h3);
		// Codes 1 and 2 with timed release and apply; 5 ms and 4 ms at 10 cycles a tick
		for (int f = 1; f <= 2; f++) begin
			wr(AABP_BRK_FUNC, 32'(f));
			cyc(1);
			chk("brake while off", 32'(brake_out), 32'(f == 2));
			wr(AABP_CMD, 32'h8);
			cyc(2);
			chk("brake on enable", 32'(brake_out), 32'(f == 1));
			chk("hold on enable", 32'(move_hold), 32'h1);
			wait_for(0, 1'b0, n);
			chk("release span", 32'(n >= 30 && n <= 55), 32'h1);
			wr(AABP_CMD, 32'h10);
			cyc(2);
			chk("brake on disable", 32'(brake_out), 32'(f == 2));
			chk("current held", 32'(motor_current), 32'h1);
			wait_for(1, 1'b0, n);
			chk("apply span", 32'(n >= 22 && n <= 45), 32'h1);
		end
		wr(AABP_BRK_FUNC, 32'h3);
		wr(AABP_CMD, 32'h8);
		cyc(3);
		chk("no release wait", 32'(move_hold), 32'h0);
		chk("freed output", 32'(brake_out), 32'h0);
		wr(AABP_CMD, 32'h10);
		cyc(3);
		chk("current off at once", 32'(motor_current), 32'h0);
		wr(AABP_BRK_FUNC, 32'h1);
		wr(AABP_BRK_REL, 32'h64);
		wr(AABP_CMD, 32'h8);
		cyc(10);
		wr(AABP_CMD, 32'h10);
		cyc(2);
		chk("hold kept", 32'(move_hold), 32'h1);
		chk("brake applied", 32'(brake_out), 32'h0);
		rdchk("apply state", AABP_STATUS, 32'h000000f8);
		wait_for(1, 1'b0, n);
		chk("apply not delayed", 32'(n <= 45), 32'h1);
		test_done();
	end
endmodule
